// [design/rail_strobe_defines.svh]
// constants for the rail strobe assignment block: offsets, resets, fields, timing
// assumes inclusion by bare name from the block and the checker
`ifndef RAIL_STROBE_DEFINES_SVH
`define RAIL_STROBE_DEFINES_SVH

// register subaddresses
`define ADDR_BUCK4_BUCK3 8'h23
`define ADDR_BACKUP 8'h24
`define ADDR_SWITCH_REG 8'h25

// reset values
`define RST_BUCK4_BUCK3 8'h75
`define RST_BACKUP 8'h12
`define RST_SWITCH_REG 8'h63

// writable bits of the backup register, the rest read zero
`define BACKUP_WR_MASK 8'h33

// field positions
`define HI_FIELD 7:4
`define LO_FIELD 3:0
`define BACKUP_B_FIELD 5:4
`define BACKUP_A_FIELD 1:0

// strobe numbers and field encodings
`define STROBE_NONE 4'h0
`define STROBE_FIRST 4'h1
`define STROBE_MAIN_FIRST 4'h3
`define STROBE_MAIN_LAST 4'ha
`define BACKUP_AT_STROBE1 2'h1
`define BACKUP_AT_STROBE2 2'h2
`define GAP_COUNT 9
`define CNT_ONE 22'h000001

// rail positions in the enable vector
`define RAIL_BUCK3 0
`define RAIL_BUCK4 1
`define RAIL_SWITCH 2
`define RAIL_REGULATOR 3
`define RAIL_BACKUP_A 4
`define RAIL_BACKUP_B 5
`define RAIL_COUNT 6
`define MAIN_RAIL_COUNT 4
`define BACKUP_KEEP_MASK 6'h30

// timing
`define CLK_PERIOD_NS 20
`define NS_PER_MS 1000000
`define GAP_SHORT_MS 2
`define GAP_LONG_MS 5
`define DOWN_FACTOR 10

`endif

// [design/rail_strobe_pkg.sv]
// types shared by the rail strobe assignment block
// assumes nothing beyond the defines header
package rail_strobe_pkg;
    typedef enum {SEQ_IDLE, SEQ_STROBE, SEQ_WAIT} seq_state_t;
    typedef enum {DIR_UP, DIR_DOWN} seq_dir_t;
endpackage

// [design/rail_strobe_assignment.sv]
// rail strobe assignment registers with the power-up and power-down strobe walker
// assumes a serial front end giving subaddress read/write strobes on clk,
// and that seal, unlock, gap selects and requests come from logic on clk
`timescale 1ns/1ps
`include "rail_strobe_defines.svh"

module rail_strobe_assignment #(
    parameter int CNT_W = 22,
    parameter int GAP_SHORT_CYCLES = (`GAP_SHORT_MS * `NS_PER_MS) / `CLK_PERIOD_NS,
    parameter int GAP_LONG_CYCLES = (`GAP_LONG_MS * `NS_PER_MS) / `CLK_PERIOD_NS
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register access from the serial front end
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // links to the rest of the sequencer
    input wire logic unlocked,
    input wire logic freshness_seal_flag,
    input wire logic [`GAP_COUNT-1:0] gap_delay_select,
    input wire logic power_down_delay_factor,
    input wire logic powerUpReq,
    input wire logic powerDownReq,
    // rail enables and sequencer state
    output logic [`RAIL_COUNT-1:0] railEnable,
    output logic [3:0] activeStrobe,
    output logic seqBusy
);

    ////////////////////////////////////////////////////////////////////////////////
    // decoding

    // out-of-range codes simply never match, so no separate disable bit is kept
    function automatic logic mainRailHit(input logic [3:0] field, input logic [3:0] strobe);
        logic inRange;
        logic atStrobe;
        inRange = (field >= `STROBE_MAIN_FIRST) && (field <= `STROBE_MAIN_LAST);
        atStrobe = (field == strobe);
        mainRailHit = inRange && atStrobe;
    endfunction

    // backup codes 0h and 3h fall out here the same way
    function automatic logic backupRailHit(input logic [1:0] field, input logic [3:0] strobe);
        logic isCoded;
        logic atStrobe;
        isCoded = (field == `BACKUP_AT_STROBE1) || (field == `BACKUP_AT_STROBE2);
        atStrobe = ({2'h0, field} == strobe);
        backupRailHit = isCoded && atStrobe;
    endfunction

    function automatic logic gapIsLong(input logic [`GAP_COUNT-1:0] sel, input logic [3:0] idx);
        gapIsLong = 1'b0;
        for (int i = 0; i < `GAP_COUNT; i++) begin
            if (idx == 4'(i)) begin
                gapIsLong = sel[i];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] buck4Buck3Sel;
    logic [7:0] backupSel;
    logic [7:0] switchRegSel;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            buck4Buck3Sel <= `RST_BUCK4_BUCK3;
            backupSel <= `RST_BACKUP;
            switchRegSel <= `RST_SWITCH_REG;
        end else if (regWrite && unlocked) begin
            case (regAddr)
                `ADDR_BUCK4_BUCK3: begin
                    buck4Buck3Sel <= regWrData;
                end
                `ADDR_BACKUP: begin
                    backupSel <= regWrData & `BACKUP_WR_MASK;
                end
                `ADDR_SWITCH_REG: begin
                    switchRegSel <= regWrData;
                end
                default: begin
                end
            endcase
        end
    end

    // reads answer one edge after the strobe; unmapped subaddresses read zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                `ADDR_BUCK4_BUCK3: begin
                    regRdData <= buck4Buck3Sel;
                end
                `ADDR_BACKUP: begin
                    regRdData <= backupSel;
                end
                `ADDR_SWITCH_REG: begin
                    regRdData <= switchRegSel;
                end
                default: begin
                    regRdData <= 8'h00;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per-rail strobe match

    logic [3:0] mainField [`MAIN_RAIL_COUNT];
    logic [`RAIL_COUNT-1:0] railHit;
    logic [3:0] strobe;

    assign mainField[`RAIL_BUCK3] = buck4Buck3Sel[`LO_FIELD];
    assign mainField[`RAIL_BUCK4] = buck4Buck3Sel[`HI_FIELD];
    assign mainField[`RAIL_SWITCH] = switchRegSel[`HI_FIELD];
    assign mainField[`RAIL_REGULATOR] = switchRegSel[`LO_FIELD];

    generate
        for (genvar g = 0; g < `MAIN_RAIL_COUNT; g++) begin : mainHit
            assign railHit[g] = mainRailHit(mainField[g], strobe);
        end
    endgenerate

    assign railHit[`RAIL_BACKUP_A] = backupRailHit(backupSel[`BACKUP_A_FIELD], strobe);
    assign railHit[`RAIL_BACKUP_B] = backupRailHit(backupSel[`BACKUP_B_FIELD], strobe);

    ////////////////////////////////////////////////////////////////////////////////
    // strobe walker

    rail_strobe_pkg::seq_state_t state;
    rail_strobe_pkg::seq_dir_t dir;
    logic [CNT_W-1:0] delayCnt;
    logic [CNT_W-1:0] next_delay;
    logic [CNT_W-1:0] baseDelay;
    logic [3:0] gapIndex;
    logic [3:0] firstStrobe;
    logic lastStrobe;

    // a sealed device starts at strobe three, so strobes one and two never run
    always_comb begin
        if (freshness_seal_flag) begin
            firstStrobe = `STROBE_MAIN_FIRST;
        end else begin
            firstStrobe = `STROBE_FIRST;
        end
    end

    // a sealed power-down stops at strobe three for the same reason
    always_comb begin
        if (dir == rail_strobe_pkg::DIR_UP) begin
            lastStrobe = (strobe == `STROBE_MAIN_LAST);
        end else begin
            lastStrobe = (strobe <= firstStrobe);
        end
    end

    // the gap after strobe k uses select bit k-1 going up and select bit k-2 going down
    always_comb begin
        if (dir == rail_strobe_pkg::DIR_UP) begin
            gapIndex = strobe - 4'h1;
        end else begin
            gapIndex = strobe - 4'h2;
        end
        baseDelay = gapIsLong(gap_delay_select, gapIndex) ? CNT_W'(GAP_LONG_CYCLES)
            : CNT_W'(GAP_SHORT_CYCLES);
        next_delay = baseDelay;
        if ((dir == rail_strobe_pkg::DIR_DOWN) && power_down_delay_factor) begin
            next_delay = CNT_W'(baseDelay * `DOWN_FACTOR);
        end
    end

    // requests arriving while a sequence runs are dropped; the engine waits for idle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= rail_strobe_pkg::SEQ_IDLE;
            strobe <= `STROBE_NONE;
        end else begin
            case (state)
                rail_strobe_pkg::SEQ_IDLE: begin
                    if (powerUpReq) begin
                        strobe <= firstStrobe;
                        state <= rail_strobe_pkg::SEQ_STROBE;
                    end else if (powerDownReq) begin
                        strobe <= `STROBE_MAIN_LAST;
                        state <= rail_strobe_pkg::SEQ_STROBE;
                    end
                end
                rail_strobe_pkg::SEQ_STROBE: begin
                    if (lastStrobe) begin
                        strobe <= `STROBE_NONE;
                        state <= rail_strobe_pkg::SEQ_IDLE;
                    end else begin
                        state <= rail_strobe_pkg::SEQ_WAIT;
                    end
                end
                rail_strobe_pkg::SEQ_WAIT: begin
                    if (delayCnt <= `CNT_ONE) begin
                        if (dir == rail_strobe_pkg::DIR_UP) begin
                            strobe <= strobe + 4'h1;
                        end else begin
                            strobe <= strobe - 4'h1;
                        end
                        state <= rail_strobe_pkg::SEQ_STROBE;
                    end
                end
                default: begin
                    strobe <= `STROBE_NONE;
                    state <= rail_strobe_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    // direction is latched with the request; power-up wins a tie
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dir <= rail_strobe_pkg::DIR_UP;
        end else if (state == rail_strobe_pkg::SEQ_IDLE) begin
            if (powerUpReq) begin
                dir <= rail_strobe_pkg::DIR_UP;
            end else if (powerDownReq) begin
                dir <= rail_strobe_pkg::DIR_DOWN;
            end
        end
    end

    // gap counter: loaded in the strobe cycle, so a gap of n means n wait cycles
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            delayCnt <= '0;
        end else if ((state == rail_strobe_pkg::SEQ_STROBE) && !lastStrobe) begin
            delayCnt <= next_delay;
        end else if (state == rail_strobe_pkg::SEQ_WAIT) begin
            if (delayCnt <= `CNT_ONE) begin
                delayCnt <= '0;
            end else begin
                delayCnt <= delayCnt - `CNT_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // rail enables

    logic [`RAIL_COUNT-1:0] offAllowed;

    // the seal check is made at the strobe itself, so a seal broken mid-sequence lets later strobes switch the backup rails off
    always_comb begin
        if (freshness_seal_flag) begin
            offAllowed = ~`BACKUP_KEEP_MASK;
        end else begin
            offAllowed = {`RAIL_COUNT{1'b1}};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            railEnable <= '0;
        end else if (state == rail_strobe_pkg::SEQ_STROBE) begin
            if (dir == rail_strobe_pkg::DIR_UP) begin
                railEnable <= railEnable | railHit;
            end else begin
                railEnable <= railEnable & ~(railHit & offAllowed);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status outputs

    // the shown strobe lines up with the rail enable change it caused
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            activeStrobe <= `STROBE_NONE;
        end else begin
            activeStrobe <= (state == rail_strobe_pkg::SEQ_STROBE) ? strobe : `STROBE_NONE;
        end
    end

    // busy lags the walker by one cycle; the engine takes a new request once idle, while busy is still high
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seqBusy <= 1'b0;
        end else begin
            seqBusy <= (state != rail_strobe_pkg::SEQ_IDLE);
        end
    end

endmodule

// [bench/rail_strobe_checker.sv]
// checker for the rail strobe block, bound onto its ports
// assumes one clk domain and the small gap counts of the bench
`timescale 1ns/1ps
`include "rail_strobe_defines.svh"
module rail_strobe_checker #(
    parameter int GAP_SHORT_CYCLES = 4,
    parameter int GAP_LONG_CYCLES = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic regRead,
    input wire logic [7:0] regRdData,
    // sequencer
    input wire logic freshness_seal_flag,
    input wire logic [`GAP_COUNT-1:0] gap_delay_select,
    input wire logic power_down_delay_factor,
    input wire logic powerUpReq,
    input wire logic powerDownReq,
    input wire logic [`RAIL_COUNT-1:0] railEnable,
    input wire logic [3:0] activeStrobe,
    input wire logic seqBusy
);
default clocking @(posedge clk); endclocking
default disable iff (!arst_n);
////////////////////////////////////////////////////////////////////////////////
// cycles since the last shown strobe; the previous strobe is cleared between walks so no stale gap
int gapCnt;
int gapWant;
logic [3:0] prevStrobe;
logic [3:0] lowIdx;
always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        gapCnt <= 0;
        prevStrobe <= 4'h0;
    end else begin
        gapCnt <= (activeStrobe != 4'h0) ? 1 : gapCnt + 1;
        if (activeStrobe != 4'h0) begin
            prevStrobe <= activeStrobe;
        end else if (!seqBusy) begin
            prevStrobe <= 4'h0;
        end
    end
end
always_comb begin
    lowIdx = (activeStrobe < prevStrobe) ? activeStrobe : prevStrobe;
    gapWant = gap_delay_select[lowIdx - 4'h1] ? GAP_LONG_CYCLES : GAP_SHORT_CYCLES;
    if (activeStrobe < prevStrobe && power_down_delay_factor) begin
        gapWant = gapWant * 10;
    end
end
////////////////////////////////////////////////////////////////////////////////
sequence idleReq;
    !seqBusy && !$past(powerUpReq) && !$past(powerDownReq);
endsequence
sequence upStart;
    ##2 activeStrobe == ($past(freshness_seal_flag, 2) ? 4'h3 : 4'h1);
endsequence
backup_bits_zero_a: assert property (
    regRead && regAddr == `ADDR_BACKUP |=> (regRdData & 8'hcc) == 8'h00)
    else $error("backup reserved bits not zero");
strobe_gap_a: assert property (
    activeStrobe != 4'h0 && prevStrobe != 4'h0 |-> gapCnt == gapWant + 1)
    else $error("strobe spacing wrong");
seal_skip_a: assert property (
    $past(freshness_seal_flag) |-> !(activeStrobe inside {4'h1, 4'h2}))
    else $error("early strobe ran while sealed");
backup_keep_a: assert property (
    $past(freshness_seal_flag) |-> !$fell(railEnable[4]) && !$fell(railEnable[5]))
    else $error("backup rail dropped while sealed");
main_rise_a: assert property (
    |(railEnable[3:0] & ~$past(railEnable[3:0])) |-> activeStrobe inside {[4'h3:4'ha]})
    else $error("main rail rose off strobes 3 to 10");
backup_rise_a: assert property (
    |(railEnable[5:4] & ~$past(railEnable[5:4])) |-> activeStrobe inside {4'h1, 4'h2})
    else $error("backup rail rose off strobes 1 and 2");
start_up_a: assert property (
    powerUpReq and idleReq |-> upStart)
    else $error("power-up began at wrong strobe");
start_down_a: assert property (
    powerDownReq && !powerUpReq and idleReq |-> ##2 activeStrobe == 4'ha)
    else $error("power-down did not begin at strobe 10");
endmodule
bind rail_strobe_assignment rail_strobe_checker #(
    .GAP_SHORT_CYCLES(GAP_SHORT_CYCLES),
    .GAP_LONG_CYCLES(GAP_LONG_CYCLES)
) chk (.clk, .arst_n, .regAddr, .regRead, .regRdData, .freshness_seal_flag,
    .gap_delay_select, .power_down_delay_factor, .powerUpReq, .powerDownReq,
    .railEnable, .activeStrobe, .seqBusy);

// [bench/rail_host_model.sv]
// host side: drives the register strobes as the serial front end would
// assumes the block samples on the rising edge; changes land at the falling edge
`timescale 1ns/1ps
module rail_host_model (
    // clock
    input wire logic clk,
    // register port
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrite,
    output logic regRead,
    output logic unlocked,
    input wire logic [7:0] regRdData
);
initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    unlocked = 1'b0;
end
task automatic unlock;
    @(negedge clk);
    unlocked = 1'b1;
endtask
// released lines show the inverse so stale values never pass
task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    regAddr = addr;
    regWrData = data;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    regAddr = ~addr;
    regWrData = ~data;
endtask
task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk);
    regAddr = addr;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    regAddr = ~addr;
    @(negedge clk);
    data = regRdData;
endtask
endmodule

// [bench/rail_strobe_assignment_tb_top.sv]
// testbench for the rail strobe block: register map, locking and four walks
// assumes gap counts shrunk to 4 and 10 cycles to keep walks short
`timescale 1ns/1ps
module rail_strobe_assignment_tb_top;
logic clk, arst_n, regWrite, regRead, unlocked, freshness_seal_flag;
logic power_down_delay_factor, powerUpReq, powerDownReq, seqBusy;
logic [7:0] regAddr, regWrData, regRdData, rd;
logic [8:0] gap_delay_select;
logic [5:0] railEnable;
logic [3:0] activeStrobe;
int err_total;
int check_count;
rail_strobe_assignment #(.GAP_SHORT_CYCLES(4), .GAP_LONG_CYCLES(10)) dut (.clk, .arst_n,
    .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .unlocked, .freshness_seal_flag,
    .gap_delay_select, .power_down_delay_factor, .powerUpReq, .powerDownReq, .railEnable,
    .activeStrobe, .seqBusy);
rail_host_model hostM (.clk, .regAddr, .regWrData, .regWrite, .regRead, .unlocked,
    .regRdData);
initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
end
////////////////////////////////////////////////////////////////////////////////
task automatic check(input string what, input logic [7:0] want, input logic [7:0] got);
    check_count++;
    if (got !== want) begin
        err_total++;
        $display("wrong value %s expected %h seen %h", what, want, got);
    end
endtask
task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
        $display("SIMULATION PASSED");
    end else begin
        $display("SIMULATION FAILED");
    end
    $finish;
endtask
// one whole walk; the seal is held for its full length
task automatic walk(input logic up, input logic seal, input logic [5:0] want);
    int n;
    @(negedge clk);
    freshness_seal_flag = seal;
    powerUpReq = up;
    powerDownReq = !up;
    @(negedge clk);
    powerUpReq = 1'b0;
    powerDownReq = 1'b0;
    repeat (2) @(negedge clk);
    for (n = 0; n < 5000 && seqBusy !== 1'b0; n++) begin
        @(negedge clk);
    end
    if (seqBusy !== 1'b0) begin
        err_total++;
        stop_test();
    end
    check("railEnable", {2'b00, want}, {2'b00, railEnable});
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    err_total = 0;
    check_count = 0;
    arst_n = 1'b0;
    freshness_seal_flag = 1'b0;
    powerUpReq = 1'b0;
    powerDownReq = 1'b0;
    gap_delay_select = 9'h0a5;
    power_down_delay_factor = 1'b1;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    hostM.read_reg(8'h23, rd);
    check("reg 23h", 8'h75, rd);
    hostM.read_reg(8'h24, rd);
    check("reg 24h", 8'h12, rd);
    hostM.read_reg(8'h25, rd);
    check("reg 25h", 8'h63, rd);
    hostM.read_reg(8'h26, rd);
    check("unmapped", 8'h00, rd);
    hostM.write_reg(8'h23, 8'hb3);
    hostM.read_reg(8'h23, rd);
    check("locked 23h", 8'h75, rd);
    hostM.unlock();
    hostM.write_reg(8'h24, 8'hff);
    hostM.read_reg(8'h24, rd);
    check("reg 24h", 8'h33, rd);
    hostM.write_reg(8'h23, 8'hb3);
    hostM.write_reg(8'h24, 8'h31);
    hostM.write_reg(8'h25, 8'h2a);
    hostM.read_reg(8'h23, rd);
    check("reg 23h", 8'hb3, rd);
    hostM.read_reg(8'h25, rd);
    check("reg 25h", 8'h2a, rd);
    walk(1'b1, 1'b0, 6'h19);
    walk(1'b0, 1'b1, 6'h10);
    walk(1'b0, 1'b0, 6'h00);
    walk(1'b1, 1'b1, 6'h09);
    stop_test();
end
endmodule
